/* core/pin_fall_sampler.sv */
// falling-edge detector for one external pin, sampled once per strobe
// assumes the pin is asynchronous to clock; strobe is a one-cycle pulse
`timescale 1ns/1ps
module pin_fall_sampler
  import timer_two_pkg::*;
(
  input  wire logic clock,
  input  wire logic resetn,
  input  wire logic pin,
  input  wire logic strobe,
  output logic      fall
);

  logic sync_first;
  logic sync_second;
  logic sample;
  logic next_sample;
  logic next_fall;

  // two-flop synchroniser
  always_ff @(posedge clock) begin
    if (!resetn) begin
      sync_first  <= 1'b1;
      sync_second <= 1'b1;
    end else begin
      sync_first  <= pin;
      sync_second <= sync_first;
    end
  end

  // compare successive samples, one pulse per high-to-low change
  always_comb begin
    next_sample = strobe ? sync_second : sample;
    next_fall   = strobe & sample & ~sync_second;
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      sample <= 1'b1;
      fall   <= 1'b0;
    end else begin
      sample <= next_sample;
      fall   <= next_fall;
    end
  end

endmodule : pin_fall_sampler

/* core/timer_two.sv */
// Functional notes
// - capture mode without enable: plain 16-bit up counter
// - capture mode qualifying trigger fall copies count into capture pair
// - qualifying trigger fall sets external event flag
// - either flag raises one shared interrupt
// - flags never cleared by hardware; software clears
// - reload mode wrap sets flag, loads capture pair
// - reload mode trigger fall reloads, sets event flag
// - counting is upward only
// - control register at C8h, resets to zero
// - no overflow flag while either clock select set
// - receive select routes overflow to first receiver
// - transmit select routes overflow to first transmitter
// - enable clear ignores trigger pin entirely
// - run bit gates counting
// - clock source selects internal ticks or count pin
// - clock select forces auto-reload on overflow
// - second pair selects baud clock for second uart
// - tick per twelve, events per 24, baud per two
// - baud mode trigger fall sets flag, no reload
// - baud mode wrap reloads from capture pair
//
// third timer/counter with capture, auto-reload and baud generator modes
// assumes the special-function bus and the uart select inputs share clock;
// count and trigger pins are asynchronous
`timescale 1ns/1ps
module timer_two
  import timer_two_pkg::*;
(
  input  wire logic      clock,
  input  wire logic      resetn,
  input  wire sfr_req_t  sfr_req,
  output logic [7:0]     sfr_rdata,
  input  wire logic      count_pin,
  input  wire logic      trigger_pin,
  input  wire logic      timer1_overflow,
  input  wire logic      second_uart_receive_clock_select,
  input  wire logic      second_uart_transmit_clock_select,
  output logic           irq,
  output uart_clocks_t   uart_clocks
);

  // register state
  control_t     control;
  logic [7:0]   count_low_byte;
  logic [7:0]   count_high_byte;
  logic [7:0]   capture_low_byte;
  logic [7:0]   capture_high_byte;
  logic [3:0]   prescale;
  logic [3:0]   sample_div;

  control_t     next_control;
  logic [7:0]   next_count_low_byte;
  logic [7:0]   next_count_high_byte;
  logic [7:0]   next_capture_low_byte;
  logic [7:0]   next_capture_high_byte;
  logic [3:0]   next_prescale;
  logic [3:0]   next_sample_div;
  logic [7:0]   next_sfr_rdata;
  logic         next_irq;
  uart_clocks_t next_uart_clocks;

  // decoded conditions
  logic [15:0]  count;
  logic [15:0]  capture;
  logic [15:0]  count_plus;
  logic [3:0]   divide;
  logic         baud_mode;
  logic         reload_mode;
  logic         tick;
  logic         sample_strobe;
  logic         count_event;
  logic         trigger_fall;
  logic         step;
  logic         overflow;
  logic         trigger;
  logic         do_capture;
  logic         do_reload;
  logic         wr_control;
  logic         wr_count_low;
  logic         wr_count_high;
  logic         wr_capture_low;
  logic         wr_capture_high;

  assign count   = {count_high_byte, count_low_byte};
  assign capture = {capture_high_byte, capture_low_byte};

  // pin samplers; one sample per twelve oscillator periods gives 24-period event limit
  pin_fall_sampler count_sampler (
    .clock  (clock),
    .resetn (resetn),
    .pin    (count_pin),
    .strobe (sample_strobe),
    .fall   (count_event)
  );

  pin_fall_sampler trigger_sampler (
    .clock  (clock),
    .resetn (resetn),
    .pin    (trigger_pin),
    .strobe (sample_strobe),
    .fall   (trigger_fall)
  );

  // mode and event decode
  always_comb begin
    wr_control      = sfr_req.wr && (sfr_req.addr == ADDR_CONTROL);
    wr_count_low    = sfr_req.wr && (sfr_req.addr == ADDR_COUNT_LOW);
    wr_count_high   = sfr_req.wr && (sfr_req.addr == ADDR_COUNT_HIGH);
    wr_capture_low  = sfr_req.wr && (sfr_req.addr == ADDR_CAPTURE_LOW);
    wr_capture_high = sfr_req.wr && (sfr_req.addr == ADDR_CAPTURE_HIGH);
    baud_mode   = control.receive_clock_select | control.transmit_clock_select;
    reload_mode = baud_mode | ~control.capture_reload_select;
    divide      = baud_mode ? BAUD_DIVIDE : TIMER_DIVIDE;
    tick        = (prescale >= divide - 4'h1);
    sample_strobe = (sample_div == SAMPLE_DIVIDE - 4'h1);
    // run gates counting; source is internal tick or sampled pin
    step        = control.run_bit
                  & (control.clock_source_select ? count_event : tick);
    overflow    = step & (count == COUNT_MAX);
    trigger     = control.external_enable & trigger_fall;
    do_capture  = trigger & ~reload_mode;
    do_reload   = (overflow & reload_mode)
                  | (trigger & reload_mode & ~baud_mode);
    count_plus  = count + 16'h0001;
  end

  // prescaler and pin sampling divider
  always_comb begin
    next_prescale   = (!control.run_bit || tick) ? 4'h0 : prescale + 4'h1;
    next_sample_div = sample_strobe ? 4'h0 : sample_div + 4'h1;
  end

  // count and capture registers
  always_comb begin
    next_count_low_byte    = count_low_byte;
    next_count_high_byte   = count_high_byte;
    next_capture_low_byte  = wr_capture_low  ? sfr_req.wdata : capture_low_byte;
    next_capture_high_byte = wr_capture_high ? sfr_req.wdata : capture_high_byte;
    if (do_reload) begin
      next_count_low_byte  = capture_low_byte;
      next_count_high_byte = capture_high_byte;
    end else if (step) begin
      next_count_low_byte  = count_plus[7:0];
      next_count_high_byte = count_plus[15:8];
    end
    if (wr_count_low) begin
      next_count_low_byte = sfr_req.wdata;
    end
    if (wr_count_high) begin
      next_count_high_byte = sfr_req.wdata;
    end
    if (do_capture) begin
      next_capture_low_byte  = count_low_byte;
      next_capture_high_byte = count_high_byte;
    end
  end

  // control register; hardware sets win over same-cycle writes
  always_comb begin
    next_control = wr_control ? control_t'(sfr_req.wdata) : control;
    if (overflow && !baud_mode) begin
      next_control.overflow_flag = 1'b1;
    end
    if (trigger) begin
      next_control.external_event_flag = 1'b1;
    end
    // flags only drop via the software write above
    next_irq = next_control.overflow_flag | next_control.external_event_flag;
  end

  // baud clock routing
  always_comb begin
    next_uart_clocks.first_rx  = control.receive_clock_select
                                 ? overflow : timer1_overflow;
    next_uart_clocks.first_tx  = control.transmit_clock_select
                                 ? overflow : timer1_overflow;
    next_uart_clocks.second_rx = second_uart_receive_clock_select
                                 ? overflow : timer1_overflow;
    next_uart_clocks.second_tx = second_uart_transmit_clock_select
                                 ? overflow : timer1_overflow;
  end

  // read data, registered, zero for unmapped addresses
  always_comb begin
    next_sfr_rdata = READ_UNMAPPED;
    if (sfr_req.rd) begin
      unique case (sfr_req.addr)
        ADDR_CONTROL:      next_sfr_rdata = control;
        ADDR_CAPTURE_LOW:  next_sfr_rdata = capture_low_byte;
        ADDR_CAPTURE_HIGH: next_sfr_rdata = capture_high_byte;
        ADDR_COUNT_LOW:    next_sfr_rdata = count_low_byte;
        ADDR_COUNT_HIGH:   next_sfr_rdata = count_high_byte;
        default:           next_sfr_rdata = READ_UNMAPPED;
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      control           <= control_t'(CONTROL_RESET);
      count_low_byte    <= COUNT_RESET[7:0];
      count_high_byte   <= COUNT_RESET[15:8];
      capture_low_byte  <= CAPTURE_RESET[7:0];
      capture_high_byte <= CAPTURE_RESET[15:8];
      prescale          <= 4'h0;
      sample_div        <= 4'h0;
      sfr_rdata         <= READ_UNMAPPED;
      irq               <= 1'b0;
      uart_clocks       <= '0;
    end else begin
      control           <= next_control;
      count_low_byte    <= next_count_low_byte;
      count_high_byte   <= next_count_high_byte;
      capture_low_byte  <= next_capture_low_byte;
      capture_high_byte <= next_capture_high_byte;
      prescale          <= next_prescale;
      sample_div        <= next_sample_div;
      sfr_rdata         <= next_sfr_rdata;
      irq               <= next_irq;
      uart_clocks       <= next_uart_clocks;
    end
  end

  // checks
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!resetn);

  sequence s_capture_edge;
    do_capture && !wr_capture_low && !wr_capture_high;
  endsequence

  sequence s_plain_step;
    step && !overflow && !wr_count_low && !wr_count_high && !do_reload;
  endsequence

  sequence s_baud_tick;
    tick && control.run_bit && baud_mode && !wr_control;
  endsequence

  chk_irq_flags: assert property (
    ##1 irq == (control.overflow_flag | control.external_event_flag))
    else $error("interrupt does not follow flags");

  chk_flags_sticky: assert property (
    control.overflow_flag && !wr_control |=> control.overflow_flag)
    else $error("overflow flag dropped without write");

  chk_baud_no_flag: assert property (
    baud_mode && !wr_control && !control.overflow_flag |=> !control.overflow_flag)
    else $error("overflow flag set in baud mode");

  chk_stopped_holds: assert property (
    !control.run_bit && !do_reload && !wr_count_low && !wr_count_high |=> $stable(count))
    else $error("count moved while stopped");

  chk_reload_wrap: assert property (
    overflow && reload_mode && !wr_count_low && !wr_count_high |=> count == $past(capture))
    else $error("no reload on wrap");

  chk_capture_edge: assert property (
    s_capture_edge |=> capture == $past(count))
    else $error("capture missed trigger");

  chk_trigger_ignored: assert property (
    !control.external_enable && !control.external_event_flag && !wr_control
    |=> !control.external_event_flag)
    else $error("event flag set with enable clear");

  chk_rx_routing: assert property (
    control.receive_clock_select && !wr_control ##1 1
    |-> uart_clocks.first_rx == $past(overflow))
    else $error("receive clock not from this timer");

  chk_count_up: assert property (
    s_plain_step |=> count == $past(count) + 16'h0001)
    else $error("count did not advance by one");

  chk_tick_rate: assert property (
    tick && control.run_bit && !baud_mode && !wr_control |=> !tick [*8])
    else $error("timer ticks too fast");

  chk_baud_rate: assert property (
    s_baud_tick ##1 !wr_control |-> !tick ##1 tick)
    else $error("baud tick not every second cycle");

  chk_tx_routing: assert property (
    control.transmit_clock_select && !wr_control |=> uart_clocks.first_tx == $past(overflow))
    else $error("transmit clock not from this timer");

  chk_rx_standard: assert property (
    !control.receive_clock_select && !wr_control |=> uart_clocks.first_rx == $past(timer1_overflow))
    else $error("receive clock not from standard timer");

  chk_tx_standard: assert property (
    !control.transmit_clock_select && !wr_control |=> uart_clocks.first_tx == $past(timer1_overflow))
    else $error("transmit clock not from standard timer");

  chk_second_rx: assert property (
    second_uart_receive_clock_select |=> uart_clocks.second_rx == $past(overflow))
    else $error("second receive clock not from this timer");

  chk_second_tx: assert property (
    second_uart_transmit_clock_select |=> uart_clocks.second_tx == $past(overflow))
    else $error("second transmit clock not from this timer");

  chk_event_sticky: assert property (
    control.external_event_flag && !wr_control |=> control.external_event_flag)
    else $error("event flag dropped without write");

  chk_overflow_wins: assert property (
    overflow && !baud_mode |=> control.overflow_flag)
    else $error("overflow lost to write");

  chk_event_wins: assert property (
    trigger |=> control.external_event_flag)
    else $error("trigger event lost");

  chk_baud_hold: assert property (
    trigger && baud_mode && !step && !wr_count_low && !wr_count_high |=> $stable(count))
    else $error("baud trigger moved count");

  chk_capture_ignored: assert property (
    !control.external_enable && !wr_capture_low && !wr_capture_high |=> $stable(capture))
    else $error("capture moved with enable clear");

  chk_reload_pin: assert property (
    trigger && reload_mode && !baud_mode && !wr_count_low && !wr_count_high
    |=> count == $past(capture))
    else $error("no reload on trigger");

  chk_pin_source: assert property (
    control.clock_source_select && !count_event && !do_reload && !wr_count_low
    && !wr_count_high |=> $stable(count))
    else $error("count moved without pin event");

  chk_wrap_zero: assert property (
    overflow && !reload_mode && !wr_count_low && !wr_count_high |=> count == 16'h0000)
    else $error("capture mode wrap not to zero");

endmodule : timer_two

/* core/timer_two_pkg.sv */
// timer two package: special-function addresses, control layout, rates, carriers
// assumes an 8-bit special-function bus with one-cycle read and write strobes
package timer_two_pkg;

  // special-function addresses
  localparam logic [7:0] ADDR_CONTROL      = 8'hC8;
  localparam logic [7:0] ADDR_CAPTURE_LOW  = 8'hCA;
  localparam logic [7:0] ADDR_CAPTURE_HIGH = 8'hCB;
  localparam logic [7:0] ADDR_COUNT_LOW    = 8'hCC;
  localparam logic [7:0] ADDR_COUNT_HIGH   = 8'hCD;

  // control field positions
  localparam int BIT_OVERFLOW      = 7;
  localparam int BIT_EXTERNAL      = 6;
  localparam int BIT_RX_SELECT     = 5;
  localparam int BIT_TX_SELECT     = 4;
  localparam int BIT_EXT_ENABLE    = 3;
  localparam int BIT_RUN           = 2;
  localparam int BIT_CLOCK_SOURCE  = 1;
  localparam int BIT_CAPTURE_RLD   = 0;

  // reset values
  localparam logic [7:0]  CONTROL_RESET = 8'h00;
  localparam logic [15:0] COUNT_RESET   = 16'h0000;
  localparam logic [15:0] CAPTURE_RESET = 16'h0000;
  localparam logic [15:0] COUNT_MAX     = 16'hFFFF;
  localparam logic [7:0]  READ_UNMAPPED = 8'h00;

  // rates in oscillator periods
  localparam logic [3:0] TIMER_DIVIDE  = 4'hC;
  localparam logic [3:0] BAUD_DIVIDE   = 4'h2;
  localparam logic [3:0] SAMPLE_DIVIDE = 4'hC;

  typedef struct packed {
    logic overflow_flag;
    logic external_event_flag;
    logic receive_clock_select;
    logic transmit_clock_select;
    logic external_enable;
    logic run_bit;
    logic clock_source_select;
    logic capture_reload_select;
  } control_t;

  typedef struct packed {
    logic [7:0] addr;
    logic       wr;
    logic       rd;
    logic [7:0] wdata;
  } sfr_req_t;

  typedef struct packed {
    logic first_rx;
    logic first_tx;
    logic second_rx;
    logic second_tx;
  } uart_clocks_t;

endpackage : timer_two_pkg

/* tb/pin_partner.sv */
// far side: count and trigger pins, standard timer overflow, baud pulse counters
// assumes pins idle high on pull-ups; everything moves on the rising clock edge
`timescale 1ns/1ps
module pin_partner
  import timer_two_pkg::*;
(
  input  wire logic         clock,
  input  wire uart_clocks_t uart_clocks,
  output logic              count_pin,
  output logic              trigger_pin,
  output logic              timer1_overflow
);
  int         pulses [4];
  logic [4:0] div;
  initial begin
    count_pin = 1'b1;
    trigger_pin = 1'b1;
    timer1_overflow = 1'b0;
    div = 5'h0;
    pulses = '{0, 0, 0, 0};
  end
  // standard timer overflow once every 32 cycles; pulse counters per uart clock
  always @(posedge clock) begin
    div <= div + 5'h1;
    timer1_overflow <= (div == 5'h1F);
    for (int i = 0; i < 4; i++) begin
      if (uart_clocks[3-i] === 1'b1) pulses[i]++;
    end
  end
  // one falling edge; low and high phases each 24 cycles
  task automatic fall(input bit trig);
    @(posedge clock);
    if (trig) trigger_pin <= 1'b0;
    else count_pin <= 1'b0;
    repeat (24) @(posedge clock);
    trigger_pin <= 1'b1;
    count_pin <= 1'b1;
    repeat (24) @(posedge clock);
  endtask : fall
endmodule : pin_partner

/* tb/tb_timer_two.sv */
// testbench for the third timer: register bus tasks, pin events, baud routing
// assumes pin_partner drives the pins and counts the uart pulses
`timescale 1ns/1ps
module tb_timer_two
  import timer_two_pkg::*;
;
  logic         clock;
  logic         resetn;
  sfr_req_t     sfr_req;
  logic [7:0]   sfr_rdata;
  logic         count_pin;
  logic         trigger_pin;
  logic         timer1_overflow;
  logic         rx2;
  logic         tx2;
  logic         irq;
  uart_clocks_t uart_clocks;
  int           errors;
  int           comparisons;
  int           seed;
  int           base [4];
  logic [15:0]  v;
  logic [15:0]  w;
  logic [7:0]   d;

  timer_two timer_two_inst (.clock(clock), .resetn(resetn), .sfr_req(sfr_req),
    .sfr_rdata(sfr_rdata), .count_pin(count_pin), .trigger_pin(trigger_pin),
    .timer1_overflow(timer1_overflow), .second_uart_receive_clock_select(rx2),
    .second_uart_transmit_clock_select(tx2), .irq(irq), .uart_clocks(uart_clocks));
  pin_partner pin_partner_inst (.clock(clock), .uart_clocks(uart_clocks),
    .count_pin(count_pin), .trigger_pin(trigger_pin), .timer1_overflow(timer1_overflow));

  initial clock = 1'b0;
  always #5 clock = ~clock;

  function automatic logic [7:0] exp_ctl(input logic [7:0] c, input logic o, input logic e);
    return {o, e, c[5:0]};
  endfunction : exp_ctl
  task automatic report_and_stop();
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : report_and_stop
  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  task automatic check8(input string what, input logic [7:0] exp, input logic [7:0] got);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : check8
  task automatic wr(input logic [7:0] a, input logic [7:0] x);
    @(posedge clock);
    sfr_req <= '{a, 1'b1, 1'b0, x};
    @(posedge clock);
    sfr_req.wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] x);
    @(posedge clock);
    sfr_req <= '{a, 1'b0, 1'b1, 8'h00};
    @(posedge clock);
    sfr_req.rd <= 1'b0;
    #1 x = sfr_rdata;
  endtask : rd
  task automatic wr16(input logic [7:0] a, input logic [15:0] x);
    wr(a, x[7:0]);
    wr(a + 8'h01, x[15:8]);
  endtask : wr16
  task automatic rd16(input logic [7:0] a, output logic [15:0] x);
    rd(a, x[7:0]);
    rd(a + 8'h01, x[15:8]);
  endtask : rd16
  task automatic wait_irq(input int bound);
    int n;
    n = 0;
    while (irq !== 1'b1 && n < bound) begin
      @(posedge clock);
      #1 n++;
    end
    check("irq wait", 16'h0001, {15'h0000, irq});
    if (irq !== 1'b1) report_and_stop();
  endtask : wait_irq
  task automatic snap();
    for (int i = 0; i < 4; i++) base[i] = pin_partner_inst.pulses[i];
  endtask : snap
  task automatic pulses_in(input int lo, input int hi);
    for (int i = 0; i < 4; i++) begin
      check("uart pulses", 16'h0001,
            {15'h0000, ((pin_partner_inst.pulses[i] - base[i]) inside {[lo:hi]})});
    end
  endtask : pulses_in

  initial begin
    seed = 54;
    errors = 0;
    comparisons = 0;
    resetn = 1'b0;
    sfr_req = '0;
    rx2 = 1'b0;
    tx2 = 1'b0;
    repeat (10) @(posedge clock);
    resetn <= 1'b1;
    rd(ADDR_CONTROL, d);
    check8("control reset", CONTROL_RESET, d);
    rd(8'h00, d);
    check8("unmapped", READ_UNMAPPED, d);
    $display("test reset done");
    wr16(ADDR_COUNT_LOW, 16'hFFFE);
    wr(ADDR_CONTROL, 8'h05);
    wait_irq(60);
    rd(ADDR_CONTROL, d);
    check8("overflow", exp_ctl(8'h05, 1'b1, 1'b0), d);
    wr(ADDR_CONTROL, 8'h00);
    rd(ADDR_CONTROL, d);
    check("flag clear", 16'h0000, {d, 7'h00, irq});
    rd16(ADDR_COUNT_LOW, v);
    repeat (100) @(posedge clock);
    rd16(ADDR_COUNT_LOW, w);
    check("count held", v, w);
    $display("test overflow done");
    v = 16'($random(seed));
    wr16(ADDR_COUNT_LOW, v);
    wr(ADDR_CONTROL, 8'h09);
    pin_partner_inst.fall(1'b1);
    rd16(ADDR_CAPTURE_LOW, w);
    check("capture", v, w);
    rd(ADDR_CONTROL, d);
    check8("event flag", exp_ctl(8'h09, 1'b0, 1'b1), {d[7:1], irq});
    wr16(ADDR_COUNT_LOW, ~v);
    wr(ADDR_CONTROL, 8'h01);
    pin_partner_inst.fall(1'b1);
    rd(ADDR_CONTROL, d);
    check8("ignored flag", 8'h01, d);
    rd16(ADDR_CAPTURE_LOW, w);
    check("ignored capture", v, w);
    wr(ADDR_CONTROL, 8'h08);
    pin_partner_inst.fall(1'b1);
    rd16(ADDR_COUNT_LOW, w);
    check("pin reload", v, w);
    rd(ADDR_CONTROL, d);
    check8("reload flag", exp_ctl(8'h08, 1'b0, 1'b1), d);
    $display("test trigger done");
    v = 16'($random(seed)) & 16'hFEFF;
    wr16(ADDR_CAPTURE_LOW, v);
    wr(ADDR_CONTROL, 8'h00);
    wr16(ADDR_COUNT_LOW, COUNT_MAX);
    wr(ADDR_CONTROL, 8'h04);
    wait_irq(40);
    rd(ADDR_CONTROL, d);
    wr(ADDR_CONTROL, 8'h00);
    check8("reload overflow", exp_ctl(8'h04, 1'b1, 1'b0), d);
    rd16(ADDR_COUNT_LOW, w);
    check("wrap reload", v, w);
    $display("test autoreload done");
    wr16(ADDR_CAPTURE_LOW, 16'hFFFE);
    wr16(ADDR_COUNT_LOW, 16'hFFFE);
    rx2 <= 1'b1;
    tx2 <= 1'b1;
    snap();
    wr(ADDR_CONTROL, 8'h35);
    repeat (200) @(posedge clock);
    wr(ADDR_CONTROL, 8'h31);
    pulses_in(40, 56);
    rd(ADDR_CONTROL, d);
    check("baud no flag", 16'h3100, {d, 7'h00, irq});
    rx2 <= 1'b0;
    tx2 <= 1'b0;
    wr(ADDR_CONTROL, 8'h00);
    snap();
    repeat (320) @(posedge clock);
    pulses_in(9, 11);
    wr16(ADDR_COUNT_LOW, 16'h1234);
    wr(ADDR_CONTROL, 8'h38);
    pin_partner_inst.fall(1'b1);
    rd(ADDR_CONTROL, d);
    check8("baud event", exp_ctl(8'h38, 1'b0, 1'b1), d);
    rd16(ADDR_COUNT_LOW, w);
    check("baud no reload", 16'h1234, w);
    $display("test baud done");
    wr16(ADDR_COUNT_LOW, COUNT_RESET);
    wr(ADDR_CONTROL, 8'h06);
    repeat (3) pin_partner_inst.fall(1'b0);
    wr(ADDR_CONTROL, 8'h00);
    rd16(ADDR_COUNT_LOW, w);
    check("pin events", 16'h0003, w);
    $display("test external count done");
    report_and_stop();
  end
endmodule : tb_timer_two
